// file: src/icc_pkg.sv
// Constants, register map and types of the two-wire bus control core
package icc_pkg;
    localparam int AW = 16;
    // Register byte addresses
    localparam logic [15:0] OFS_DATA = 16'hFFA5;
    localparam logic [15:0] OFS_CTRL = 16'hFFA6;
    localparam logic [15:0] OFS_SVA = 16'hFFA8;
    localparam logic [15:0] OFS_STAT = 16'hFFA9;
    localparam logic [15:0] OFS_FLAG = 16'hFFAA;
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] SVA_RST = 8'h00;
    localparam logic [7:0] STAT_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    // Control register fields
    localparam int C_EN = 7;
    localparam int C_EXIT = 6;
    localparam int C_WCAN = 5;
    localparam int C_SPIE = 4;
    localparam int C_WTIM = 3;
    localparam int C_ACKE = 2;
    localparam int C_STT = 1;
    localparam int C_SPT = 0;
    // Flag register fields
    localparam int F_RSV = 0;
    localparam int F_INIT = 1;
    localparam int F_BSY = 6;
    localparam int F_FAIL = 7;
    // Status register fields
    localparam int S_MST = 7;
    localparam int S_COI = 6;
    localparam int S_EXC = 5;
    localparam int S_TRC = 4;
    localparam int S_ACKD = 3;
    localparam int S_STD = 2;
    localparam int S_WAIT = 1;
    localparam int S_STBY = 0;
    // Clock counts within a byte and the extension code prefix
    localparam logic [3:0] N_BYTE = 4'h8;
    localparam logic [3:0] N_ACK = 4'h9;
    localparam logic [3:0] EXT_HI = 4'h0;
    // Serial clock half periods, least times rounded up to cycles
    localparam int CLK_NS = 5;
    localparam int HALF_STD_NS = 5000;
    localparam int HALF_FAST_NS = 1250;
    localparam logic [9:0] HALF_STD_CYC = 10'((HALF_STD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [9:0] HALF_FAST_CYC = 10'((HALF_FAST_NS + CLK_NS - 1) / CLK_NS);
    // Start and stop generator states
    typedef enum logic [1:0] {
        G_IDLE = 2'b00,
        G_STA = 2'b01,
        G_STP1 = 2'b10,
        G_STP2 = 2'b11
    } icc_gen_e;
endpackage

// file: src/icc_prescaler.sv
// Prescaler giving the serial clock half-period tick
`timescale 1ns/1ps
module icc_prescaler (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic fast_i,
    output logic tick_o
);
    import icc_pkg::*;

    logic [9:0] count;

    // Selected half period and end of count
    wire [9:0] limit = fast_i ? HALF_FAST_CYC : HALF_STD_CYC;
    wire last = count >= 10'(limit - 10'h001);

    // Counter held at zero while no master activity needs pacing
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            count <= 10'h000;
            tick_o <= 1'b0;
        end else if (!run_i) begin
            count <= 10'h000;
            tick_o <= 1'b0;
        end else begin
            count <= last ? 10'h000 : 10'(count + 10'h001);
            tick_o <= last;
        end
    end
endmodule

// file: src/icc_core.sv
// Two-wire bus control core: registers, bit engine, start and stop logic
// How it works
// - Own slave address register holds the local address, cleared to zero by reset.
// - Bit 0 of the own slave address always reads zero.
// - A data output latch holds the level driven onto the data line.
// - Interrupt on received address equal to own address, or extension code.
// - Clock counter counts serial clocks and marks each complete eight-bit byte.
// - Interrupt at eighth or ninth falling edge per wait timing, and on stop.
// - As master the core drives the serial clock from the prescaler tick.
// - Start trigger makes a start; refused with fail flag if busy and reservation off.
// - Stop trigger, control bit 0, makes a stop condition.
// - Bus busy follows start and stop; initial state from initial state select.
// - Control register resets to zero with enable down to stop trigger fields.
// - Clearing enable stops the core and clears status, fail, busy and monitors.
// - Exit abandons transfer, floats lines, clears named flags, enters standby, self-clears.
// - Standby lasts until a stop, or an address or extension code match after a start.
// - Wait cancel releases the clock wait and clears itself once released.
// - Cancel in the ninth-clock wait while transmitting floats data, clears direction.
// - Exit and wait cancel do nothing while the core is disabled.
// - Enabling with clock high and data low detects a start at once.
// - Wait timing zero waits at eighth clock, one at ninth; address waits ninth.
`timescale 1ns/1ps
module icc_core (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [icc_pkg::AW-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic clk_sel_i,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    output logic serial_interrupt_o,
    output logic clock_level_monitor_o,
    output logic data_level_monitor_o
);
    import icc_pkg::*;

    // Decode of one register address
    function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] ofs);
        return a == ofs;
    endfunction

    logic scl_m, scl_s, sda_m, sda_s, scl_p, sda_p;
    logic enable, en_q, spie, wtim, acke, stt, spt, wcan;
    logic rsv, init_sel, bus_busy, start_fail;
    logic [7:1] own;
    logic [7:0] stat;
    logic [7:0] shift;
    logic [3:0] cnt;
    logic in_xfer, addr_phase, w9, tick;
    icc_gen_e gen;

    // Two-stage synchronisers for the bus lines
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
        end else begin
            scl_m <= scl_i;
            scl_s <= scl_m;
            sda_m <= sda_i;
            sda_s <= sda_m;
        end
    end

    // Previous levels, held high while off so enabling sees a low data line
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end else if (!enable) begin
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end else begin
            scl_p <= scl_s;
            sda_p <= sda_s;
        end
    end

    // Register strobes and bus events
    wire wr_ctrl = wr_i & hit(addr_i, OFS_CTRL);
    wire wr_sva = wr_i & hit(addr_i, OFS_SVA);
    wire wr_flag = wr_i & hit(addr_i, OFS_FLAG);
    wire wr_data = wr_i & hit(addr_i, OFS_DATA);
    wire scl_rise = scl_s & ~scl_p;
    wire scl_fall = ~scl_s & scl_p;
    wire start_det = enable & scl_s & scl_p & sda_p & ~sda_s;
    wire stop_det = enable & scl_s & scl_p & ~sda_p & sda_s;
    wire do_exit = wr_ctrl & wdata_i[C_EXIT] & enable;
    wire en_rise = enable & ~en_q;

    // Bit engine qualifiers
    wire run_bits = in_xfer & ~stat[S_WAIT] & (gen == G_IDLE);
    wire [3:0] n_cnt = 4'(cnt + 4'h1);
    wire fall8 = run_bits & scl_fall & (n_cnt == N_BYTE);
    wire fall9 = run_bits & scl_fall & (n_cnt == N_ACK);
    wire addr_ok = own == shift[7:1];
    wire ext_ok = shift[7:4] == EXT_HI;
    wire ack_now = addr_phase ? (addr_ok | (ext_ok & acke)) : acke;
    wire hold8 = fall8 & ~addr_phase & ~wtim;
    wire hold9 = fall9 & (addr_phase | wtim);
    wire release_w = stat[S_WAIT] & (wr_data | wcan);

    // Start and stop requests
    wire refuse = stt & rsv & bus_busy & ~stat[S_MST] & ~stat[S_STBY];
    wire start_go = stt & ~bus_busy & ~stat[S_STBY] & tick;
    wire stop_go = spt & stat[S_MST] & stat[S_WAIT];

    // Read-back views and read selection
    wire [7:0] ctrl_rd = {enable, 1'b0, wcan, spie, wtim, acke, stt, spt};
    wire [7:0] flag_rd = {start_fail, bus_busy, 4'h0, init_sel, rsv};
    wire [7:0] rd_mux = hit(addr_i, OFS_DATA) ? shift :
                        hit(addr_i, OFS_CTRL) ? ctrl_rd :
                        hit(addr_i, OFS_SVA) ? {own, 1'b0} :
                        hit(addr_i, OFS_STAT) ? stat :
                        hit(addr_i, OFS_FLAG) ? flag_rd : 8'h00;

    icc_prescaler u_pre (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(enable & (stt | spt | stat[S_MST])),
        .fast_i(clk_sel_i),
        .tick_o(tick)
    );

    // Software-owned configuration
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            enable <= CTRL_RST[C_EN];
            spie <= CTRL_RST[C_SPIE];
            wtim <= CTRL_RST[C_WTIM];
            acke <= CTRL_RST[C_ACKE];
            own <= SVA_RST[7:1];
            rsv <= 1'b0;
            init_sel <= 1'b0;
            en_q <= 1'b0;
        end else begin
            en_q <= enable;
            if (wr_ctrl) begin
                enable <= wdata_i[C_EN];
                spie <= wdata_i[C_SPIE];
                wtim <= wdata_i[C_WTIM];
                acke <= wdata_i[C_ACKE];
            end
            if (wr_sva) begin
                own <= wdata_i[7:1];
            end
            if (wr_flag) begin
                rsv <= wdata_i[F_RSV];
                init_sel <= wdata_i[F_INIT];
            end
        end
    end

    // Transfer engine, start and stop generation, flags
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            stat <= STAT_RST;
            shift <= DATA_RST;
            in_xfer <= 1'b0;
            addr_phase <= 1'b0;
            w9 <= 1'b0;
            cnt <= 4'h0;
            bus_busy <= 1'b0;
            start_fail <= 1'b0;
            stt <= 1'b0;
            spt <= 1'b0;
            wcan <= 1'b0;
            gen <= G_IDLE;
            scl_oe_n_o <= 1'b1;
            sda_oe_n_o <= 1'b1;
            serial_interrupt_o <= 1'b0;
        end else if (!enable) begin
            stat <= STAT_RST;
            if (wr_data) begin
                shift <= wdata_i;
            end
            in_xfer <= 1'b0;
            addr_phase <= 1'b0;
            w9 <= 1'b0;
            cnt <= 4'h0;
            bus_busy <= 1'b0;
            start_fail <= 1'b0;
            stt <= 1'b0;
            spt <= 1'b0;
            wcan <= 1'b0;
            gen <= G_IDLE;
            scl_oe_n_o <= 1'b1;
            sda_oe_n_o <= 1'b1;
            serial_interrupt_o <= 1'b0;
        end else begin
            serial_interrupt_o <= 1'b0;
            if (en_rise) begin
                bus_busy <= ~init_sel;
            end
            if (wr_ctrl && wdata_i[C_STT]) begin
                stt <= 1'b1;
                start_fail <= 1'b0;
            end
            if (wr_ctrl && wdata_i[C_SPT]) begin
                spt <= 1'b1;
            end
            if (wr_ctrl && wdata_i[C_WCAN]) begin
                wcan <= 1'b1;
            end
            if (wr_data) begin
                shift <= wdata_i;
            end
            if (do_exit) begin
                stat <= STAT_RST;
                stat[S_STBY] <= 1'b1;
                in_xfer <= 1'b0;
                stt <= 1'b0;
                spt <= 1'b0;
                wcan <= 1'b0;
                gen <= G_IDLE;
                scl_oe_n_o <= 1'b1;
                sda_oe_n_o <= 1'b1;
            end else begin
                // Master clock: release on a tick, pull low once seen high
                if (stat[S_MST] && !stat[S_WAIT] && gen == G_IDLE && tick) begin
                    if (!scl_oe_n_o) begin
                        scl_oe_n_o <= 1'b1;
                    end else if (scl_s) begin
                        scl_oe_n_o <= 1'b0;
                    end
                end
                // Sample on rising edges; transmitter takes the ack at the ninth
                if (run_bits && scl_rise) begin
                    if (cnt < N_BYTE) begin
                        shift <= {shift[6:0], sda_s};
                    end else if (stat[S_TRC]) begin
                        stat[S_ACKD] <= ~sda_s;
                    end
                end
                // Count and steer the data latch on falling edges
                if (run_bits && scl_fall) begin
                    cnt <= fall9 ? 4'h0 : n_cnt;
                    if (n_cnt < N_BYTE) begin
                        sda_oe_n_o <= ~stat[S_TRC] | shift[7];
                    end
                    if (fall8) begin
                        sda_oe_n_o <= stat[S_TRC] | ~ack_now;
                        if (addr_phase && !stat[S_MST]) begin
                            stat[S_COI] <= addr_ok;
                            stat[S_EXC] <= ext_ok;
                            if (!addr_ok && !ext_ok) begin
                                in_xfer <= 1'b0;
                            end else begin
                                stat[S_STBY] <= 1'b0;
                            end
                        end
                        if (hold8) begin
                            stat[S_WAIT] <= 1'b1;
                            w9 <= 1'b0;
                            scl_oe_n_o <= 1'b0;
                            serial_interrupt_o <= 1'b1;
                        end
                    end
                    if (fall9) begin
                        sda_oe_n_o <= hold9 | ~stat[S_TRC] | shift[7];
                        addr_phase <= 1'b0;
                        if (addr_phase) begin
                            stat[S_TRC] <= stat[S_MST] ? ~shift[0] : shift[0];
                        end
                        if (hold9) begin
                            stat[S_WAIT] <= 1'b1;
                            w9 <= 1'b1;
                            scl_oe_n_o <= 1'b0;
                            serial_interrupt_o <= 1'b1;
                        end
                    end
                end
                // Wait release by a data write or by wait cancel
                if (release_w) begin
                    stat[S_WAIT] <= 1'b0;
                    wcan <= 1'b0;
                    scl_oe_n_o <= 1'b1;
                    if (w9 && stat[S_TRC] && !wr_data) begin
                        sda_oe_n_o <= 1'b1;
                        stat[S_TRC] <= 1'b0;
                    end else if (w9) begin
                        sda_oe_n_o <= ~stat[S_TRC] | (wr_data ? wdata_i[7] : shift[7]);
                    end else begin
                        sda_oe_n_o <= stat[S_TRC] | ~acke;
                    end
                end
                // Start and stop generation paced by the prescaler tick
                unique case (gen)
                    G_IDLE: begin
                        if (refuse) begin
                            stt <= 1'b0;
                            start_fail <= 1'b1;
                        end else if (start_go) begin
                            sda_oe_n_o <= 1'b0;
                            gen <= G_STA;
                        end else if (stop_go) begin
                            sda_oe_n_o <= 1'b0;
                            stat[S_WAIT] <= 1'b0;
                            gen <= G_STP1;
                        end
                    end
                    G_STA: begin
                        if (tick) begin
                            scl_oe_n_o <= 1'b0;
                            stat[S_MST] <= 1'b1;
                            stat[S_TRC] <= 1'b1;
                            stat[S_WAIT] <= 1'b1;
                            w9 <= 1'b1;
                            stt <= 1'b0;
                            gen <= G_IDLE;
                        end
                    end
                    G_STP1: begin
                        if (tick) begin
                            scl_oe_n_o <= 1'b1;
                            gen <= G_STP2;
                        end
                    end
                    G_STP2: begin
                        if (tick && scl_s) begin
                            sda_oe_n_o <= 1'b1;
                            spt <= 1'b0;
                            stat[S_MST] <= 1'b0;
                            gen <= G_IDLE;
                        end
                    end
                endcase
            end
            // Bus conditions, placed last so they win over an exit or a clear
            if (start_det) begin
                stat[S_STD] <= 1'b1;
                stat[S_COI] <= 1'b0;
                stat[S_EXC] <= 1'b0;
                stat[S_TRC] <= 1'b0;
                bus_busy <= 1'b1;
                in_xfer <= 1'b1;
                addr_phase <= 1'b1;
                cnt <= 4'h0;
            end
            if (stop_det) begin
                bus_busy <= 1'b0;
                in_xfer <= 1'b0;
                stat[S_STD] <= 1'b0;
                stat[S_STBY] <= 1'b0;
                stat[S_MST] <= 1'b0;
                stat[S_WAIT] <= 1'b0;
                serial_interrupt_o <= spie;
            end
        end
    end

    // Read data, line level monitors, open-drain data levels
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
            scl_o <= 1'b0;
            sda_o <= 1'b0;
            clock_level_monitor_o <= 1'b0;
            data_level_monitor_o <= 1'b0;
        end else begin
            rdata_o <= rd_i ? rd_mux : 8'h00;
            clock_level_monitor_o <= enable & scl_s;
            data_level_monitor_o <= enable & sda_s;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_sva_wr_rd;
        wr_sva ##1 (rd_i && hit(addr_i, OFS_SVA) && !wr_sva);
    endsequence
    sequence s_enable_low;
        $rose(enable) && scl_s && !sda_s;
    endsequence
    sequence s_cancel;
        wcan && stat[S_WAIT] && !do_exit;
    endsequence

    a_own_addr_read: assert property (s_sva_wr_rd |=> rdata_o == {$past(wdata_i[7:1], 2), 1'b0})
        else $error("own address read-back wrong");
    a_exit_floats: assert property (do_exit && !stop_det |=>
            scl_oe_n_o && sda_oe_n_o && !stat[S_MST] && stat[S_STBY] && !stt)
        else $error("exit did not float the bus");
    a_exit_inert: assert property (wr_ctrl && wdata_i[C_EXIT] && !enable |=> !stat[S_STBY])
        else $error("exit acted while disabled");
    a_off_clears: assert property (!enable |=>
            !bus_busy && !start_fail && stat == 8'h00 && !clock_level_monitor_o)
        else $error("disable left state behind");
    a_start_refused: assert property (refuse && gen == G_IDLE && !do_exit |=> start_fail && !stt)
        else $error("busy start not refused");
    a_stop_irq: assert property (stop_det && spie |=> serial_interrupt_o)
        else $error("no interrupt on stop");
    a_wait_eight: assert property (hold8 && !do_exit && !stop_det |=>
            stat[S_WAIT] && serial_interrupt_o && !scl_oe_n_o)
        else $error("eighth-clock wait missing");
    a_wait_cancel: assert property (s_cancel |=> !stat[S_WAIT] && !wcan ##1 !stat[S_WAIT])
        else $error("wait cancel did not release");
    a_busy_track: assert property (start_det |=> bus_busy && stat[S_STD])
        else $error("start did not mark bus busy");
    a_enable_start: assert property (s_enable_low |=> stat[S_STD])
        else $error("start not seen on enable");
endmodule

// file: tb/icc_peer.sv
// Peer slave on the two-wire bus that acknowledges its own address
`timescale 1ns/1ps
module icc_peer #(
    parameter logic [6:0] DEV = 7'h3A
) (
    input wire logic clk_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic hold_i,
    output logic sda_rel_o
);
    logic scl_q = 1'b1;
    logic sda_q = 1'b1;
    logic ack = 1'b0;
    logic [7:0] sh = 8'h00;
    int cnt = 0;
    // Data line stays released at idle unless acking or told to hold low
    assign sda_rel_o = !(ack || hold_i);
    // Follows start, stop and clock edges as a slave would
    always @(posedge clk_i) begin
        scl_q <= scl_i;
        sda_q <= sda_i;
        if (scl_i && sda_q != sda_i) begin
            cnt <= 0;
        end else if (!scl_q && scl_i) begin
            sh <= {sh[6:0], sda_i};
            cnt <= cnt + 1;
        end else if (scl_q && !scl_i) begin
            ack <= (cnt == 8) && (sh[7:1] == DEV);
        end
    end
endmodule

// file: tb/icc_core_bench.sv
// Self-checking bench of the control core with a peer slave on the bus
`timescale 1ns/1ps
module icc_core_bench;
    import icc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [15:0] addr_i = 16'h0000;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic hold = 1'b0;
    logic [7:0] rdata_o;
    logic scl_o, scl_oe_n_o, sda_o, sda_oe_n_o, serial_interrupt_o, sda_rel, scl_w, sda_w;
    logic clock_level_monitor_o, data_level_monitor_o, scl_q;
    logic [8:0] wire_bits = 9'h000;
    logic [31:0] seed = 32'h0000_0057;
    int irq_cnt = 0, rise_cnt = 0, miscompares = 0, check_count = 0, k;
    // Open-drain lines with pull-ups
    assign scl_w = scl_oe_n_o ? 1'b1 : scl_o;
    assign sda_w = (sda_oe_n_o ? 1'b1 : sda_o) & sda_rel;
    always #2.5 clk_i = ~clk_i;
    icc_core icc_core_i (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .clk_sel_i(1'b1), .scl_i(scl_w),
        .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_n_o(sda_oe_n_o), .serial_interrupt_o(serial_interrupt_o),
        .clock_level_monitor_o(clock_level_monitor_o),
        .data_level_monitor_o(data_level_monitor_o));
    icc_peer #(.DEV(7'h3A)) icc_peer_i (.clk_i(clk_i), .scl_i(scl_w), .sda_i(sda_w),
        .hold_i(hold), .sda_rel_o(sda_rel));
    // Counts interrupt pulses and clock rises, keeps the bits seen on the wire
    always @(posedge clk_i) begin
        scl_q <= scl_w;
        if (serial_interrupt_o === 1'b1) irq_cnt <= irq_cnt + 1;
        if (scl_q === 1'b0 && scl_w === 1'b1) begin
            rise_cnt <= rise_cnt + 1;
            wire_bits <= {wire_bits[7:0], sda_w};
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // Reads a register and compares the masked value
    task automatic rc(input string nm, input logic [15:0] a, input logic [7:0] m,
        input logic [7:0] e);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk(nm, rdata_o & m, e);
        @(posedge clk_i);
    endtask
    task automatic wait_irq();
        int n;
        n = irq_cnt;
        for (int i = 0; i < 20000 && irq_cnt == n; i++) @(posedge clk_i);
        if (irq_cnt == n) begin
            chk("interrupt", 8'h00, 8'h01);
            test_done();
        end
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rc("control", OFS_CTRL, 8'hFF, CTRL_RST);
        rc("own address", OFS_SVA, 8'hFF, SVA_RST);
        rc("unmapped", 16'hFFA0, 8'hFF, 8'h00);
        // Random own addresses, written while no start is seen
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            addr_i <= OFS_SVA;
            wdata_i <= seed[7:0];
            wr_i <= 1'b1;
            @(posedge clk_i);
            wr_i <= 1'b0;
            rc("own address", OFS_SVA, 8'hFF, seed[7:0] & 8'hFE);
        end
        wr(OFS_CTRL, 8'h60);
        rc("control", OFS_CTRL, 8'hFF, 8'h00);
        $display("test 1 over");
        // Enabling with data held low sees a start, exit drops it
        hold <= 1'b1;
        wr(OFS_CTRL, 8'h80);
        repeat (6) @(posedge clk_i);
        rc("start seen", OFS_STAT, 8'(1 << S_STD), 8'(1 << S_STD));
        chk("data level", {7'h00, data_level_monitor_o}, 8'h00);
        wr(OFS_CTRL, 8'hC0);
        rc("start seen", OFS_STAT, 8'(1 << S_STD), 8'h00);
        rc("control", OFS_CTRL, 8'hFF, 8'h80);
        hold <= 1'b0;
        wr(OFS_CTRL, 8'h00);
        rc("status", OFS_STAT, 8'hFF, STAT_RST);
        chk("clock level", {7'h00, clock_level_monitor_o}, 8'h00);
        $display("test 2 over");
        // Start refused while busy with reservation off
        wr(OFS_FLAG, 8'h01);
        wr(OFS_CTRL, 8'h80);
        wr(OFS_CTRL, 8'h82);
        rc("flags", OFS_FLAG, 8'hFF, 8'hC1);
        chk("data drive", {7'h00, sda_oe_n_o}, 8'h01);
        wr(OFS_CTRL, 8'h00);
        rc("flags", OFS_FLAG, 8'hFF, 8'h01);
        $display("test 3 over");
        // Master start, acknowledged address byte, then stop
        wr(OFS_FLAG, 8'h02);
        wr(OFS_CTRL, 8'h98);
        rc("flags", OFS_FLAG, 8'hFF, 8'h02);
        wr(OFS_CTRL, 8'h9A);
        for (int i = 0; i < 5000 && scl_oe_n_o !== 1'b0; i++) @(posedge clk_i);
        if (scl_oe_n_o !== 1'b0) begin
            chk("start drive", 8'h01, 8'h00);
            test_done();
        end
        rc("master", OFS_STAT, 8'(1 << S_MST), 8'(1 << S_MST));
        k = rise_cnt;
        wr(OFS_DATA, 8'h74);
        wait_irq();
        chk("clock rises", 8'(rise_cnt - k), 8'h09);
        chk("wire bits", wire_bits[8:1], 8'h74);
        rc("ack seen", OFS_STAT, 8'(1 << S_ACKD), 8'(1 << S_ACKD));
        // Cancel in the ninth-clock wait floats data; the next byte waits at the eighth clock
        k = rise_cnt;
        wr(OFS_CTRL, 8'hB0);
        rc("cancelled", OFS_STAT, 8'(1 << S_TRC | 1 << S_WAIT), 8'h00);
        chk("data drive", {7'h00, sda_oe_n_o}, 8'h01);
        rc("control", OFS_CTRL, 8'hFF, 8'h90);
        wait_irq();
        chk("clock rises", 8'(rise_cnt - k), 8'h08);
        chk("wire bits", wire_bits[7:0], 8'hFF);
        rc("waiting", OFS_STAT, 8'(1 << S_WAIT), 8'(1 << S_WAIT));
        wr(OFS_CTRL, 8'h91);
        wait_irq();
        rc("flags", OFS_FLAG, 8'hFF, 8'h02);
        chk("lines", {6'h00, scl_w, sda_w}, 8'h03);
        $display("test 4 over");
        test_done();
    end
endmodule
